// ==== rtl/pmsc_top.sv ====
// Pattern machine signal control: word sequencer, pin generation, APB slave
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pmsc_map.svh"

// Functional notes
// - A machine-selected bank has its chip select level and timing from pattern words.
// - Pattern drives a byte strobe only where port size, size and address allow.
// - Lane 0 is D[0:7], lane 1 D[8:15], lane 2 D[16:23], lane 3 lowest.
// - 32-bit port: byte by A[30:31], half by A[30], word all four lanes.
// - 16-bit port: byte by A[31], else lanes 0,1; 8-bit port lane 0 only.
// - Timer and command requests choose strobe lanes from port size alone.
// - Each pattern line takes two word bits, one per bus clock phase fall.
// - First read/write cycle: line five at phase one follows option select bit.
// - Pattern line zero may output an address bit chosen in the mode register.
// - First loop-marked word starts a loop and loads the repeat counter.
// - Next loop-marked word decrements; nonzero returns to start, else continues.
// - After exit a new loop may start; every final word that does not branch clears loop state.
// - Repeat count comes from read, write, timer or command field per request kind.
// - Error acknowledge or reset from outside is held pending and acts at the end of the next branch-enabled word.
// - Exception on a branch-enabled word jumps next to pattern word 0x3C.
// - Without branch enable, run on until enabled word branches or final word.
// - After the branch, consecutive words run until a final word.
// - Address pins carry requested, multiplexed or mode address register value.
// - First read/write cycle address follows the first-cycle mux option bit.
// - Mux settings 000, 001, 010 map internal bits per the shift table.
// - Mux settings 011, 100, 101 map internal bits per the shift table.
// - Word source 00 requested, 10 multiplexed, 11 mode address register.
// - A final-marked word completes service of the current request.
module pmsc_top
    import pmsc_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_REQ_VALID,
    input wire logic [2:0] I_REQ_KIND,
    input wire logic [1:0] I_REQ_SIZE,
    input wire logic [1:0] I_REQ_BANK,
    input wire logic [0:31] I_REQ_ADDR,
    output logic O_REQ_READY,
    output logic O_DONE,
    input wire logic I_TEA_N,
    input wire logic I_EXT_RESET_N,
    output logic [3:0] O_CS_N,
    output logic [0:3] O_BS_N,
    output logic [5:0] O_GPL_N,
    output logic [0:31] O_ADDR,
    output logic O_BUSY
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [31:0] ram [0:`PMSC_RAM_WORDS-1];
    logic [31:0] mode_reg, opt_reg, mar_reg, prdata_reg;
    logic [5:0] raddr_reg, pc_reg, loop_start_reg;
    logic [3:0] loop_cnt_reg, loop_field_reg;
    logic loop_on_reg, exc_pend_reg, in_exc_reg, phase_reg, first_reg;
    logic pready_reg, cmd_pend_reg, done_reg;
    logic [5:0] cmd_start_reg;
    logic [1:0] cmd_bank_reg, bank_reg;
    logic [0:3] lane_reg;
    pmsc_addr_t req_addr_reg;
    logic rw_req_reg;
    pmsc_state_e state_reg;
    logic [2:0] tea_sync_reg, rst_sync_reg;

    // ----------------------------------------------------------------
    // Register fields
    // ----------------------------------------------------------------
    logic [2:0] row_mux;
    logic pattern_line_zero_addr_en;
    logic [4:0] pattern_line_zero_idx;
    pmsc_port_e port_sz;
    logic first_mux, line5_sel;
    logic [3:0] bank_machine;
    assign row_mux = mode_reg[2:0];
    assign pattern_line_zero_addr_en = mode_reg[3];
    assign pattern_line_zero_idx = mode_reg[8:4];
    assign port_sz = pmsc_port_e'(opt_reg[1:0]);
    assign first_mux = opt_reg[2];
    assign line5_sel = opt_reg[3];
    assign bank_machine = opt_reg[7:4];

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic pmsc_addr_t row_mux_addr(input pmsc_addr_t a,
                                                input logic [2:0] sel);
        int shift;
        int first;
        pmsc_addr_t m;
        shift = 8;
        first = 18;
        m = '0;
        case (sel)
            3'b000: begin shift = 8; first = 18; end
            3'b001: begin shift = 9; first = 17; end
            3'b010: begin shift = 10; first = 16; end
            3'b011: begin shift = 11; first = 17; end
            3'b100: begin shift = 12; first = 16; end
            3'b101: begin shift = 13; first = 17; end
            default: begin shift = 8; first = 32; end
        endcase
        for (int k = 16; k < 32; k++) begin
            if (k >= first) begin
                m[k] = a[k - shift];
            end
        end
        return m;
    endfunction

    function automatic logic [0:3] lane_mask(input pmsc_kind_e kind,
                                             input logic [1:0] size,
                                             input pmsc_port_e port,
                                             input logic a30,
                                             input logic a31);
        logic [0:3] l;
        l = 4'b0000;
        if (kind == PMSC_TIMER || kind == PMSC_COMMAND) begin
            size = 2'b10;
        end
        case (port)
            PMSC_PORT_32: begin
                case (size)
                    2'b00: l[{a30, a31}] = 1'b1;
                    2'b01: l = a30 ? 4'b0011 : 4'b1100;
                    default: l = 4'b1111;
                endcase
            end
            PMSC_PORT_16: begin
                l = (size == 2'b00) ? (a31 ? 4'b0100 : 4'b1000)
                                    : 4'b1100;
            end
            default: l = 4'b1000;
        endcase
        return l;
    endfunction

    // ----------------------------------------------------------------
    // Exception inputs
    // ----------------------------------------------------------------
    // Three stages; a low level counts once the last two stages agree
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tea_sync_reg <= 3'b111;
            rst_sync_reg <= 3'b111;
        end else begin
            tea_sync_reg <= {tea_sync_reg[1:0], I_TEA_N};
            rst_sync_reg <= {rst_sync_reg[1:0], I_EXT_RESET_N};
        end
    end

    logic exc_seen;
    assign exc_seen = (tea_sync_reg[2:1] == 2'b00) ||
                      (rst_sync_reg[2:1] == 2'b00);

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state so that read data comes straight from a flop
    logic apb_acc, apb_wr, mapped;
    assign apb_acc = I_PSEL && I_PENABLE && pready_reg;
    assign apb_wr = apb_acc && I_PWRITE;
    always_comb begin
        case (I_PADDR)
            `PMSC_MODE_OFS, `PMSC_OPT_OFS, `PMSC_MAR_OFS, `PMSC_RADDR_OFS,
            `PMSC_RDATA_OFS, `PMSC_STAT_OFS, `PMSC_CMD_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= I_PSEL && I_PENABLE && !pready_reg;
            if (I_PSEL && I_PENABLE && !pready_reg && !I_PWRITE) begin
                case (I_PADDR)
                    `PMSC_MODE_OFS: prdata_reg <= mode_reg;
                    `PMSC_OPT_OFS: prdata_reg <= {24'h00_0000, opt_reg[7:0]};
                    `PMSC_MAR_OFS: prdata_reg <= mar_reg;
                    `PMSC_RADDR_OFS: prdata_reg <= {26'h000_0000, raddr_reg};
                    `PMSC_RDATA_OFS: prdata_reg <= ram[raddr_reg];
                    `PMSC_STAT_OFS: prdata_reg <= {18'h0_0000, loop_cnt_reg,
                        pc_reg, loop_on_reg, in_exc_reg, exc_pend_reg,
                        state_reg == PMSC_RUN};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign O_PREADY = pready_reg;
    assign O_PRDATA = prdata_reg;
    assign O_PSLVERR = pready_reg && !mapped;

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            mode_reg <= `PMSC_MODE_RST;
            opt_reg <= `PMSC_OPT_RST;
            mar_reg <= `PMSC_MAR_RST;
            raddr_reg <= 6'h00;
        end else if (apb_wr) begin
            case (I_PADDR)
                `PMSC_MODE_OFS: mode_reg <= {4'h0, I_PWDATA[27:0]};
                `PMSC_OPT_OFS: opt_reg <= {24'h00_0000, I_PWDATA[7:0]};
                `PMSC_MAR_OFS: mar_reg <= I_PWDATA;
                `PMSC_RADDR_OFS: raddr_reg <= I_PWDATA[5:0];
                default: ;
            endcase
        end
    end

    // Pattern RAM has no reset; software loads it before use
    always_ff @(posedge I_SYS_CLK) begin
        if (apb_wr && I_PADDR == `PMSC_RDATA_OFS) begin
            ram[raddr_reg] <= I_PWDATA;
        end
    end

    // ----------------------------------------------------------------
    // Command requests from software
    // ----------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cmd_pend_reg <= 1'b0;
            cmd_start_reg <= 6'h00;
            cmd_bank_reg <= 2'b00;
        end else if (apb_wr && I_PADDR == `PMSC_CMD_OFS) begin
            cmd_pend_reg <= 1'b1;
            cmd_start_reg <= I_PWDATA[5:0];
            cmd_bank_reg <= I_PWDATA[9:8];
        end else if (state_reg == PMSC_IDLE) begin
            cmd_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    logic [31:0] word;
    logic start_req, start_cmd, word_end, branch, loop_back;
    logic [3:0] cnt_next;
    pmsc_kind_e req_kind;
    assign word = ram[pc_reg];
    assign req_kind = pmsc_kind_e'(I_REQ_KIND);
    assign start_cmd = state_reg == PMSC_IDLE && cmd_pend_reg;
    assign start_req = state_reg == PMSC_IDLE && !cmd_pend_reg &&
                       I_REQ_VALID;
    assign word_end = state_reg == PMSC_RUN && phase_reg;
    assign branch = (exc_pend_reg || exc_seen) && word[`PMSC_W_EXCEPTION_BRANCH_ENABLE] &&
                    !in_exc_reg;
    assign cnt_next = loop_cnt_reg - 4'h1;
    // Revisiting the start word must not count as reaching the loop end
    assign loop_back = loop_on_reg && cnt_next != 4'h0 &&
                       pc_reg != loop_start_reg;

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_reg <= PMSC_IDLE;
            pc_reg <= 6'h00;
            phase_reg <= 1'b0;
            first_reg <= 1'b0;
            done_reg <= 1'b0;
            bank_reg <= 2'b00;
            lane_reg <= 4'b0000;
            req_addr_reg <= '0;
            rw_req_reg <= 1'b0;
            loop_field_reg <= 4'h0;
        end else begin
            done_reg <= 1'b0;
            if (start_cmd) begin
                state_reg <= bank_machine[cmd_bank_reg] ? PMSC_RUN : PMSC_IDLE;
                done_reg <= !bank_machine[cmd_bank_reg];
                pc_reg <= cmd_start_reg;
                bank_reg <= cmd_bank_reg;
                lane_reg <= lane_mask(PMSC_COMMAND, 2'b10, port_sz,
                                      1'b0, 1'b0);
                req_addr_reg <= mar_reg;
                rw_req_reg <= 1'b0;
                loop_field_reg <= mode_reg[27:24];
                phase_reg <= 1'b0;
                first_reg <= 1'b1;
            end else if (start_req) begin
                state_reg <= bank_machine[I_REQ_BANK] ? PMSC_RUN : PMSC_IDLE;
                done_reg <= !bank_machine[I_REQ_BANK];
                bank_reg <= I_REQ_BANK;
                lane_reg <= lane_mask(req_kind, I_REQ_SIZE, port_sz,
                                      I_REQ_ADDR[30], I_REQ_ADDR[31]);
                req_addr_reg <= I_REQ_ADDR;
                rw_req_reg <= req_kind <= PMSC_WRITE_BURST;
                phase_reg <= 1'b0;
                first_reg <= 1'b1;
                case (req_kind)
                    PMSC_READ_SINGLE: begin
                        pc_reg <= `PMSC_RSS_START;
                        loop_field_reg <= mode_reg[15:12];
                    end
                    PMSC_READ_BURST: begin
                        pc_reg <= `PMSC_RBS_START;
                        loop_field_reg <= mode_reg[15:12];
                    end
                    PMSC_WRITE_SINGLE: begin
                        pc_reg <= `PMSC_WSS_START;
                        loop_field_reg <= mode_reg[19:16];
                    end
                    PMSC_WRITE_BURST: begin
                        pc_reg <= `PMSC_WBS_START;
                        loop_field_reg <= mode_reg[19:16];
                    end
                    default: begin
                        pc_reg <= `PMSC_PTS_START;
                        loop_field_reg <= mode_reg[23:20];
                    end
                endcase
            end else if (state_reg == PMSC_RUN) begin
                phase_reg <= !phase_reg;
                if (word_end) begin
                    first_reg <= 1'b0;
                    if (branch) begin
                        pc_reg <= `PMSC_EXC_START;
                    end else if (word[`PMSC_W_LAST]) begin
                        state_reg <= PMSC_IDLE;
                        done_reg <= 1'b1;
                    end else if (word[`PMSC_W_LOOP] && loop_back) begin
                        pc_reg <= loop_start_reg;
                    end else begin
                        pc_reg <= pc_reg + 6'h01;
                    end
                end
            end
        end
    end

    // Loop state
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            loop_on_reg <= 1'b0;
            loop_start_reg <= 6'h00;
            loop_cnt_reg <= 4'h0;
        end else if (start_req || start_cmd) begin
            loop_on_reg <= 1'b0;
        end else if (word_end && !branch) begin
            if (word[`PMSC_W_LAST]) begin
                loop_on_reg <= 1'b0;
            end else if (word[`PMSC_W_LOOP]) begin
                if (!loop_on_reg) begin
                    loop_on_reg <= 1'b1;
                    loop_start_reg <= pc_reg;
                    loop_cnt_reg <= loop_field_reg;
                end else if (pc_reg != loop_start_reg) begin
                    loop_cnt_reg <= cnt_next;
                    loop_on_reg <= loop_back;
                end
            end
        end
    end

    // Exception flag; the clear on the branch wins over a new exception
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            exc_pend_reg <= 1'b0;
            in_exc_reg <= 1'b0;
        end else if (state_reg != PMSC_RUN) begin
            exc_pend_reg <= 1'b0;
            in_exc_reg <= 1'b0;
        end else if (word_end && branch) begin
            exc_pend_reg <= 1'b0;
            in_exc_reg <= 1'b1;
        end else if (exc_seen && !in_exc_reg) begin
            exc_pend_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pin generation
    // ----------------------------------------------------------------
    // Phase 0 applies the phase-one falling edge values, phase 1 phase two
    logic [1:0] word_address_source;
    logic use_first;
    pmsc_addr_t addr_sel;
    assign word_address_source = {word[`PMSC_W_AMX_HI], word[`PMSC_W_AMX_LO]};
    assign use_first = first_reg && rw_req_reg;
    always_comb begin
        if (use_first) begin
            addr_sel = first_mux ? row_mux_addr(req_addr_reg, row_mux)
                                 : req_addr_reg;
        end else begin
            case (word_address_source)
                2'b10: addr_sel = row_mux_addr(req_addr_reg, row_mux);
                2'b11: addr_sel = mar_reg;
                default: addr_sel = req_addr_reg;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_CS_N <= 4'b1111;
            O_BS_N <= 4'b1111;
            O_ADDR <= '0;
        end else if (state_reg == PMSC_RUN) begin
            O_CS_N <= 4'b1111;
            O_CS_N[bank_reg] <= phase_reg ? word[`PMSC_W_CS2]
                                          : word[`PMSC_W_CS1];
            for (int l = 0; l < 4; l++) begin
                O_BS_N[l] <= !lane_reg[l] ||
                    (phase_reg ? word[`PMSC_W_BS2]
                               : word[`PMSC_W_BS1]);
            end
            if (!phase_reg) begin
                O_ADDR <= addr_sel;
            end
        end else begin
            O_CS_N <= 4'b1111;
            O_BS_N <= 4'b1111;
        end
    end

    generate
        for (genvar g = 0; g < 6; g++) begin : g_line
            always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
                if (!I_NRST) begin
                    O_GPL_N[g] <= 1'b1;
                end else if (state_reg == PMSC_RUN) begin
                    if (g == 0 && pattern_line_zero_addr_en) begin
                        O_GPL_N[g] <= req_addr_reg[pattern_line_zero_idx];
                    end else if (g == 5 && use_first && !phase_reg) begin
                        O_GPL_N[g] <= line5_sel;
                    end else begin
                        O_GPL_N[g] <= word[`PMSC_W_GPL + 2 * g +
                                           (phase_reg ? 1 : 0)];
                    end
                end else begin
                    O_GPL_N[g] <= 1'b1;
                end
            end
        end
    endgenerate

    assign O_DONE = done_reg;
    assign O_BUSY = state_reg == PMSC_RUN;
    assign O_REQ_READY = state_reg == PMSC_IDLE && !cmd_pend_reg;

endmodule
`default_nettype wire

// ==== common/pmsc_map.svh ====
// Register offsets, field positions, reset values and pattern RAM layout of the pattern machine
`ifndef PMSC_MAP_SVH
`define PMSC_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMSC_MODE_OFS 12'h000
`define PMSC_OPT_OFS 12'h004
`define PMSC_MAR_OFS 12'h008
`define PMSC_RADDR_OFS 12'h00C
`define PMSC_RDATA_OFS 12'h010
`define PMSC_STAT_OFS 12'h014
`define PMSC_CMD_OFS 12'h018

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMSC_MODE_RST 32'h0000_0000
`define PMSC_OPT_RST 32'h0000_0000
`define PMSC_MAR_RST 32'h0000_0000

// ----------------------------------------------------------------
// Pattern word fields
// ----------------------------------------------------------------
`define PMSC_W_CS1 0
`define PMSC_W_CS2 1
`define PMSC_W_BS1 2
`define PMSC_W_BS2 3
`define PMSC_W_GPL 4
`define PMSC_W_LOOP 24
`define PMSC_W_EXCEPTION_BRANCH_ENABLE 25
`define PMSC_W_AMX_HI 26
`define PMSC_W_AMX_LO 27
`define PMSC_W_LAST 31

// ----------------------------------------------------------------
// Pattern RAM layout
// ----------------------------------------------------------------
`define PMSC_RAM_WORDS 64
`define PMSC_EXC_START 6'h3C
`define PMSC_RSS_START 6'h00
`define PMSC_RBS_START 6'h08
`define PMSC_WSS_START 6'h18
`define PMSC_WBS_START 6'h20
`define PMSC_PTS_START 6'h30

`endif

// ==== common/pmsc_pkg.sv ====
// Types shared by the pattern machine signal control block
package pmsc_pkg;
    typedef enum logic [2:0] {
        PMSC_READ_SINGLE,
        PMSC_READ_BURST,
        PMSC_WRITE_SINGLE,
        PMSC_WRITE_BURST,
        PMSC_TIMER,
        PMSC_COMMAND
    } pmsc_kind_e;

    typedef enum logic [1:0] {
        PMSC_PORT_32 = 2'b00,
        PMSC_PORT_8 = 2'b01,
        PMSC_PORT_16 = 2'b10
    } pmsc_port_e;

    typedef enum logic {
        PMSC_IDLE,
        PMSC_RUN
    } pmsc_state_e;

    typedef logic [0:31] pmsc_addr_t;
endpackage

// ==== testbench/pmsc_asserts.sv ====
// Port-level assertions for the pattern machine
`timescale 1ns/1ns
`default_nettype none
module pmsc_asserts (
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_REQ_VALID,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_REQ_READY,
    input wire logic O_DONE,
    input wire logic O_BUSY,
    input wire logic [3:0] O_CS_N,
    input wire logic [0:3] O_BS_N,
    input wire logic [5:0] O_GPL_N
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    a_done_pulse: assert property (O_DONE |=> !O_DONE && !O_BUSY)
        else $error("done pulse too long");
    a_accept_runs: assert property ((I_REQ_VALID && O_REQ_READY)
        |=> O_BUSY || O_DONE)
        else $error("accepted request did not start");
    a_busy_blocks: assert property (O_BUSY |-> !O_REQ_READY)
        else $error("ready while busy");
    a_busy_bound: assert property ($rose(O_BUSY) |-> ##[1:1000] !O_BUSY)
        else $error("pattern never finished");
    a_cs_single: assert property ($onehot0(~O_CS_N))
        else $error("more than one bank selected");
    a_idle_pins: assert property (!O_BUSY && !$past(O_BUSY)
        && !$past(O_DONE) |-> O_CS_N == 4'hF && O_BS_N == 4'hF
        && O_GPL_N == 6'h3F)
        else $error("pins not idle");
    a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
        else $error("pslverr without pready");
    a_one_wait: assert property (I_PSEL && I_PENABLE && !$past(I_PENABLE)
        |-> !O_PREADY ##1 O_PREADY)
        else $error("access not one wait state");
endmodule
bind pmsc_top pmsc_asserts u_chk (.I_SYS_CLK, .I_NRST, .I_PSEL,
    .I_PENABLE, .I_REQ_VALID, .O_PREADY, .O_PSLVERR, .O_REQ_READY,
    .O_DONE, .O_BUSY, .O_CS_N, .O_BS_N, .O_GPL_N);
`default_nettype wire

// ==== testbench/pmsc_mem_model.sv ====
// External memory stand-in that can answer with a transfer error
`timescale 1ns/1ns
`default_nettype none
module pmsc_mem_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_err_en,
    input wire logic [3:0] i_cs_n,
    output logic o_tea_n,
    output logic o_reset_n
);
    // Error only while selected, so it drops once the branch lifts CS
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) o_tea_n <= 1'b1;
        else o_tea_n <= !(i_err_en && i_cs_n != 4'hF);
    end
    assign o_reset_n = 1'b1;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the pattern machine signal control block
`timescale 1ns/1ns
`default_nettype none
`include "pmsc_map.svh"
module tb;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, rv = 0, err_en = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd, rdat;
    logic prdy, perr, rerr, rrdy, done, busy, tea_n, xrst_n;
    logic [2:0] rk = 0;
    logic [1:0] rs = 0, rb = 0;
    logic [0:31] ra = 0, ad, e, a;
    logic [3:0] cs_n, s_cs [32];
    logic [0:3] bs_n, s_bs [32];
    logic [5:0] gpl_n, s_gpl [32];
    logic [0:31] s_ad [32];
    int bad_count = 0, cmp_count = 0, n;
    logic [5:0] wa [13] = '{6'h00, 6'h01, 6'h02, 6'h18, 6'h19, 6'h1A,
        6'h1B, 6'h1C, 6'h30, 6'h31, 6'h32, 6'h3C, 6'h3D};
    logic [31:0] wd [13] = '{32'h0000_FF30, 32'h0400_FF30, 32'h8C00_FF30,
        32'h0000_FF30, 32'h0000_FF30, 32'h0200_FF30, 32'h0200_FF30,
        32'h8000_FF30, 32'h0100_FF30, 32'h0100_FF30, 32'h8000_FF30,
        32'h0000_000F, 32'h8000_000F};
    logic [1:0] pt [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
    logic [1:0] sz [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
    logic [1:0] lo2 [6] = '{2'h0, 2'h3, 2'h2, 2'h0, 2'h1, 2'h2};
    logic [0:3] ex [6] = '{4'h7, 4'hE, 4'hC, 4'h0, 4'hB, 4'h7};
    int lo [6] = '{18, 17, 16, 17, 16, 17};
    pmsc_top DUT (.I_SYS_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
        .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_REQ_VALID(rv), .I_REQ_KIND(rk), .I_REQ_SIZE(rs),
        .I_REQ_BANK(rb), .I_REQ_ADDR(ra), .O_REQ_READY(rrdy),
        .O_DONE(done), .I_TEA_N(tea_n), .I_EXT_RESET_N(xrst_n),
        .O_CS_N(cs_n), .O_BS_N(bs_n), .O_GPL_N(gpl_n), .O_ADDR(ad),
        .O_BUSY(busy));
    pmsc_mem_model u_mem (.i_clk(clk), .i_nrst(nrst), .i_err_en(err_en),
        .i_cs_n(cs_n), .o_tea_n(tea_n), .o_reset_n(xrst_n));
    initial forever #25 clk = ~clk;
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
        cmp_count++;
        if (s !== x) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic apb(logic w, logic [11:0] ofs, logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        pa <= ofs;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (prdy !== 1'b1 && k < 20);
        rdat = prd;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        chk("apb wait", 1, k < 20);
        if (k >= 20) wrap_up();
    endtask
    // Snapshot index m holds the pins just after the m-th edge
    task automatic req(logic [2:0] k, logic [1:0] s, logic [0:31] x);
        rk <= k;
        rs <= s;
        ra <= x;
        rv <= 1'b1;
        @(posedge clk);
        rv <= 1'b0;
        n = 0;
        forever begin
            #1;
            s_cs[n] = cs_n;
            s_bs[n] = bs_n;
            s_gpl[n] = gpl_n;
            s_ad[n] = ad;
            if (done === 1'b1) break;
            if (n == 31) chk("done wait", 0, 1);
            if (n == 31) wrap_up();
            @(posedge clk);
            n++;
        end
        @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, `PMSC_MODE_OFS, 0);
        chk("mode", `PMSC_MODE_RST, rdat);
        apb(1'b0, `PMSC_OPT_OFS, 0);
        chk("opt", `PMSC_OPT_RST, rdat);
        apb(1'b0, 12'hFFC, 0);
        chk("unmapped", 32'h0000_0001, {rdat != 0, rerr});
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, `PMSC_RADDR_OFS, 32'(wa[i]));
            apb(1'b1, `PMSC_RDATA_OFS, wd[i]);
        end
        apb(1'b1, `PMSC_MAR_OFS, 32'h1234_5678);
        for (int i = 0; i < 6; i++) begin
            a = 32'h5A3C_9E10 + 32'(i << 12) | 32'(lo2[i]);
            e = (a >> (8 + i)) & (32'hFFFF_FFFF >> lo[i]);
            apb(1'b1, `PMSC_MODE_OFS, 32'(i));
            apb(1'b1, `PMSC_OPT_OFS, 32'h0000_0010 | 32'(pt[i]));
            req(3'h0, sz[i], a);
            chk("words", 6, n);
            chk("cs", 4'hE, s_cs[1]);
            chk("bs", ex[i], s_bs[1]);
            chk("gpl", 6'h1D, s_gpl[1]);
            chk("mux", e, s_ad[3]);
            chk("mar", 32'h1234_5678, s_ad[5]);
        end
        apb(1'b1, `PMSC_MODE_OFS, 32'h0000_01F8);
        apb(1'b1, `PMSC_OPT_OFS, 32'h0000_0014);
        req(3'h0, 2'h2, 32'h0000_0100);
        chk("pattern_line_zero", 6'h1C, s_gpl[1]);
        chk("first addr", 32'h0000_0001, s_ad[1]);
        apb(1'b1, `PMSC_MODE_OFS, 32'h0020_5000);
        apb(1'b1, `PMSC_OPT_OFS, 32'h0000_0012);
        for (int j = 0; j < 2; j++) begin
            req(3'h4, 2'h0, 32'h0000_0001);
            chk("loop words", 10, n);
            chk("timer bs", 4'h3, s_bs[1]);
        end
        apb(1'b1, `PMSC_OPT_OFS, 32'h0000_0010);
        err_en <= 1'b1;
        req(3'h2, 2'h2, 32'h0F0F_0F0C);
        err_en <= 1'b0;
        chk("col addr", 32'h0F0F_0F0C, s_ad[3]);
        chk("exc gpl", 6'h00, s_gpl[n-1]);
        chk("exc cs", 4'hF, s_cs[n-1]);
        chk("exc late", 1, n >= 8);
        repeat (8) @(posedge clk);
        rb <= 2'h1;
        req(3'h0, 2'h2, 32'h0000_0000);
        chk("off bank", 0, n);
        chk("off cs", 4'hF, s_cs[0]);
        wrap_up();
    end
endmodule
`default_nettype wire
